/* File: src/pik_consts.svh */
// Constants for the panel indicator and key control block
// Summary of operation
// - Controls-active lamp lit while this panel holds local operating control.
// - Pre-discharge lamp lit while any releasing zone is activated, not yet discharging.
// - Discharge lamp lit while any releasing zone is discharging agent.
// - Manual release forces immediate agent release, bypassing delay and abort.
// - Fire lamp flashes unacknowledged, steady after acknowledge, held until cleared and reset.
// - Pre-alarm lamp flashes then steady; action type also needs a reset.
// - Security lamp flashes then steady; off only after clearing and reset.
// - Supervisory lamp flashes then steady; latching inputs also need a reset.
// - Trouble lamp flashes then steady; off when trouble clears, no reset.
// - Silenced lamp steady after silence, flashes when partly silenced, off on reset/drill.
// - Point-disabled lamp lit while any device is disabled.
// - Acknowledge silences sounder, steadies flashing lamps, logs acknowledge message.
// - Acknowledge also commands remote annunciators to silence their sounders.
// - With several events, display steps every 3 s or on acknowledge.
// - Local control 0 ignores acknowledge and keeps the sounder silent.
// - Silence key stops sounder and silenceable circuits, lights lamp, logs message.
// - Local control 0 or 2 ignores the silence and drill keys.
// - Reset key clears active inputs, interrupts resettable power, logs message.
// - Reset detaches the panel from the network for 60 s.
// - Conditions still present after reset reactivate circuits, outputs and indicators.
// - Reset re-sounds the sounder for troubles but does not re-flash their lamp; local control 0 ignores reset.
// - Drill held 2 s turns on silenceable circuits, clears silenced lamp, logs evacuate.
// - Lamp test lights everything and sounds; beyond 5 s shows software revisions.
`ifndef PIK_CONSTS_SVH
`define PIK_CONSTS_SVH
`define PIK_CLK_HZ 125000000
`define PIK_CYC_PER_MS (`PIK_CLK_HZ / 1000)
`define PIK_SCROLL_MS 3000
`define PIK_DECOUPLE_MS 60000
`define PIK_DRILL_HOLD_MS 2000
`define PIK_LAMP_REV_MS 5000
`define PIK_BLINK_HALF_MS 500
`define PIK_DEBOUNCE_MS 20
`define PIK_POWER_OFF_MS 1000
`define PIK_ADDR_CTRL 8'h00
`define PIK_ADDR_STATUS 8'h04
`define PIK_ADDR_LOG 8'h08
`define PIK_CTRL_LC_RESET 2'h3
`define PIK_LC_NONE 2'h0
`define PIK_LC_PARTIAL 2'h2
`define PIK_CAT_FIRE 0
`define PIK_CAT_PRE 1
`define PIK_CAT_SEC 2
`define PIK_CAT_SUP 3
`define PIK_CAT_TRB 4
`endif

/* File: src/pik_pkg.sv */
// Types shared by the panel indicator and key control block
package pik_pkg;
    typedef enum logic [3:0] {
        PIK_LOG_NONE = 4'h0,
        PIK_LOG_ACK = 4'h1,
        PIK_LOG_SILENCE = 4'h2,
        PIK_LOG_RESET = 4'h4,
        PIK_LOG_EVAC = 4'h8
    } pik_log_e;

    typedef struct packed {
        logic ack;
        logic silence;
        logic sysReset;
        logic drill;
        logic lampTest;
    } pik_keys_s;

    typedef struct packed {
        logic holdsControl;
        logic acPower;
        logic abortActive;
        logic fireCond;
        logic preAlarmCond;
        logic preAlarmAction;
        logic securityCond;
        logic supervisoryCond;
        logic supervisoryLatching;
        logic troubleCond;
        logic disabledAny;
        logic partialSilence;
        logic multiEvents;
    } pik_status_s;

    typedef struct packed {
        logic controlsActive;
        logic power;
        logic preDischarge;
        logic discharge;
        logic abortActive;
        logic fireAlarm;
        logic preAlarm;
        logic security;
        logic supervisory;
        logic trouble;
        logic silenced;
        logic pointDisabled;
    } pik_lamps_s;
endpackage

/* File: src/pik_panel_control.sv */
// Front panel lamps, control keys and key actions
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "pik_consts.svh"
module pik_panel_control #(
    parameter int ZONES = 4,
    parameter longint unsigned SCROLL_CYC = `PIK_SCROLL_MS * `PIK_CYC_PER_MS,
    parameter longint unsigned DECOUPLE_CYC = 64'(`PIK_DECOUPLE_MS) * `PIK_CYC_PER_MS,
    parameter longint unsigned DRILL_CYC = `PIK_DRILL_HOLD_MS * `PIK_CYC_PER_MS,
    parameter longint unsigned LAMP_REV_CYC = `PIK_LAMP_REV_MS * `PIK_CYC_PER_MS,
    parameter longint unsigned BLINK_CYC = `PIK_BLINK_HALF_MS * `PIK_CYC_PER_MS,
    parameter longint unsigned DEBOUNCE_CYC = `PIK_DEBOUNCE_MS * `PIK_CYC_PER_MS,
    parameter longint unsigned POWER_OFF_CYC = `PIK_POWER_OFF_MS * `PIK_CYC_PER_MS
) (
    input wire logic clock,
    input wire logic resetn,
    input wire pik_pkg::pik_keys_s keyPins,
    input wire logic manualReleasePin,
    input wire pik_pkg::pik_status_s status,
    input wire logic [ZONES-1:0] preDischargeZones,
    input wire logic [ZONES-1:0] dischargeZones,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    output pik_pkg::pik_lamps_s lamps,
    output logic sounder,
    output logic silenceableOn,
    output logic resettablePowerOff,
    output logic netDecouple,
    output logic annunSilenceCmd,
    output logic logValid,
    output pik_pkg::pik_log_e logCode,
    output logic scrollNext,
    output logic releaseNow,
    output logic displayAllOn,
    output logic showRevision
);
    if (ZONES < 1 || ZONES > 32 || SCROLL_CYC < 2 || DECOUPLE_CYC < 2 || DRILL_CYC < 2 ||
        LAMP_REV_CYC < 2 || BLINK_CYC < 2 || DEBOUNCE_CYC < 2 || POWER_OFF_CYC < 2 ||
        DECOUPLE_CYC >= 64'h100_0000_0000) begin : gParamCheck
        $error("pik_panel_control: unsupported parameter value");
    end

    localparam int NK = 5;
    localparam int NC = 5;
    logic [1:0] rstSync_q;
    logic rstn;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end
    assign rstn = rstSync_q[1];

    // Registers
    logic [1:0] localCtrl_q;
    pik_pkg::pik_log_e lastLog_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            localCtrl_q <= `PIK_CTRL_LC_RESET;
        end else if (regWr && regAddr == `PIK_ADDR_CTRL) begin
            localCtrl_q <= regWrData[1:0];
        end
    end

    // Blink source shared by every flashing lamp
    logic [39:0] blinkCnt_q;
    logic blink_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            blinkCnt_q <= 40'h0;
            blink_q <= 1'b0;
        end else if (blinkCnt_q == 40'(BLINK_CYC - 1)) begin
            blinkCnt_q <= 40'h0;
            blink_q <= ~blink_q;
        end else begin
            blinkCnt_q <= blinkCnt_q + 40'h1;
        end
    end

    // Key synchronisers and debouncers
    logic [NK-1:0] keyRaw;
    logic [NK-1:0] keyMeta_q;
    logic [NK-1:0] keySync_q;
    logic [NK-1:0] keyStable_q;
    logic [NK-1:0] keyPress_q;
    assign keyRaw = keyPins;
    genvar k;
    generate
        for (k = 0; k < NK; k++) begin : gKey
            logic [39:0] dbCnt_q;
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    keyMeta_q[k] <= 1'b0;
                    keySync_q[k] <= 1'b0;
                end else begin
                    keyMeta_q[k] <= keyRaw[k];
                    keySync_q[k] <= keyMeta_q[k];
                end
            end
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    dbCnt_q <= 40'h0;
                    keyStable_q[k] <= 1'b0;
                    keyPress_q[k] <= 1'b0;
                end else if (keySync_q[k] == keyStable_q[k]) begin
                    dbCnt_q <= 40'h0;
                    keyPress_q[k] <= 1'b0;
                end else if (dbCnt_q == 40'(DEBOUNCE_CYC - 1)) begin
                    dbCnt_q <= 40'h0;
                    keyStable_q[k] <= keySync_q[k];
                    keyPress_q[k] <= keySync_q[k];
                end else begin
                    dbCnt_q <= dbCnt_q + 40'h1;
                    keyPress_q[k] <= 1'b0;
                end
            end
        end
    endgenerate

    // Struct field order: ack, silence, sysReset, drill, lampTest
    logic lcNone;
    logic lcPartial;
    logic ackDo;
    logic silenceDo;
    logic resetDo;
    logic drillDo;
    logic lampTestHeld;
    assign lcNone = localCtrl_q == `PIK_LC_NONE;
    assign lcPartial = localCtrl_q == `PIK_LC_PARTIAL;
    assign ackDo = keyPress_q[4] && !lcNone;
    assign silenceDo = keyPress_q[3] && !lcNone && !lcPartial;
    assign resetDo = keyPress_q[2] && !lcNone;
    assign lampTestHeld = keyStable_q[0];

    // Hold timers for drill and lamp test
    logic [39:0] drillCnt_q;
    logic drillFired_q;
    logic [39:0] lampCnt_q;
    assign drillDo = keyStable_q[1] && !drillFired_q && drillCnt_q == 40'(DRILL_CYC - 1) &&
                     !lcNone && !lcPartial;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            drillCnt_q <= 40'h0;
            drillFired_q <= 1'b0;
        end else if (!keyStable_q[1]) begin
            drillCnt_q <= 40'h0;
            drillFired_q <= 1'b0;
        end else if (drillCnt_q == 40'(DRILL_CYC - 1)) begin
            drillFired_q <= 1'b1;
        end else begin
            drillCnt_q <= drillCnt_q + 40'h1;
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lampCnt_q <= 40'h0;
        end else if (!lampTestHeld) begin
            lampCnt_q <= 40'h0;
        end else if (lampCnt_q != 40'(LAMP_REV_CYC)) begin
            lampCnt_q <= lampCnt_q + 40'h1;
        end
    end

    // Alarm categories: fire, pre-alarm, security, supervisory, trouble
    logic [NC-1:0] condVec;
    logic [NC-1:0] latchMode;
    logic [NC-1:0] condPrev_q;
    logic [NC-1:0] latched_q;
    logic [NC-1:0] unack_q;
    logic [NC-1:0] catLamp;
    logic [NC-1:0] rise;
    assign condVec = {status.troubleCond, status.supervisoryCond, status.securityCond,
                      status.preAlarmCond, status.fireCond};
    // Troubles never latch; they clear with their condition
    assign latchMode = {1'b0, status.supervisoryLatching, 1'b1, status.preAlarmAction, 1'b1};
    genvar c;
    generate
        for (c = 0; c < NC; c++) begin : gCat
            assign rise[c] = condVec[c] && !condPrev_q[c];
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    condPrev_q[c] <= 1'b0;
                    latched_q[c] <= 1'b0;
                    unack_q[c] <= 1'b0;
                end else begin
                    condPrev_q[c] <= condVec[c];
                    // Set wins over the clear of a reset in the same cycle
                    if (condVec[c] && latchMode[c]) begin
                        latched_q[c] <= 1'b1;
                    end else if (resetDo) begin
                        latched_q[c] <= 1'b0;
                    end
                    if (rise[c] || (resetDo && condVec[c] && c != `PIK_CAT_TRB)) begin
                        unack_q[c] <= 1'b1;
                    end else if (ackDo) begin
                        unack_q[c] <= 1'b0;
                    end
                end
            end
            assign catLamp[c] = (condVec[c] || latched_q[c]) && (!unack_q[c] || blink_q);
        end
    endgenerate

    // Sounder and silenceable circuits
    logic sound_q;
    logic nac_q;
    logic silenced_q;
    logic reactivate;
    assign reactivate = resetDo && (|condVec);
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sound_q <= 1'b0;
        end else if (|rise[3:0] || rise[4] || reactivate) begin
            sound_q <= 1'b1;
        end else if (ackDo || silenceDo) begin
            sound_q <= 1'b0;
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            nac_q <= 1'b0;
        end else if (rise[`PIK_CAT_FIRE] || drillDo || (resetDo && condVec[`PIK_CAT_FIRE])) begin
            nac_q <= 1'b1;
        end else if (silenceDo || resetDo) begin
            nac_q <= 1'b0;
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            silenced_q <= 1'b0;
        end else if (resetDo || drillDo) begin
            silenced_q <= 1'b0;
        end else if (silenceDo) begin
            silenced_q <= 1'b1;
        end
    end

    // Event outputs: log, annunciator command, resettable power, network decouple
    logic [39:0] powerCnt_q;
    logic [39:0] decoupleCnt_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            logValid <= 1'b0;
            logCode <= pik_pkg::PIK_LOG_NONE;
            annunSilenceCmd <= 1'b0;
        end else begin
            logValid <= resetDo || silenceDo || ackDo || drillDo;
            annunSilenceCmd <= ackDo;
            if (resetDo) begin
                logCode <= pik_pkg::PIK_LOG_RESET;
            end else if (silenceDo) begin
                logCode <= pik_pkg::PIK_LOG_SILENCE;
            end else if (ackDo) begin
                logCode <= pik_pkg::PIK_LOG_ACK;
            end else if (drillDo) begin
                logCode <= pik_pkg::PIK_LOG_EVAC;
            end
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lastLog_q <= pik_pkg::PIK_LOG_NONE;
        end else if (logValid) begin
            lastLog_q <= logCode;
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            powerCnt_q <= 40'h0;
            resettablePowerOff <= 1'b0;
        end else if (resetDo) begin
            powerCnt_q <= 40'(POWER_OFF_CYC - 1);
            resettablePowerOff <= 1'b1;
        end else if (powerCnt_q != 40'h0) begin
            powerCnt_q <= powerCnt_q - 40'h1;
        end else begin
            resettablePowerOff <= 1'b0;
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            decoupleCnt_q <= 40'h0;
            netDecouple <= 1'b0;
        end else if (resetDo) begin
            decoupleCnt_q <= 40'(DECOUPLE_CYC - 1);
            netDecouple <= 1'b1;
        end else if (decoupleCnt_q != 40'h0) begin
            decoupleCnt_q <= decoupleCnt_q - 40'h1;
        end else begin
            netDecouple <= 1'b0;
        end
    end

    // Display scroll timer, restarted by each acknowledge
    logic [39:0] scrollCnt_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            scrollCnt_q <= 40'h0;
            scrollNext <= 1'b0;
        end else if (!status.multiEvents) begin
            scrollCnt_q <= 40'h0;
            scrollNext <= 1'b0;
        end else if (ackDo || scrollCnt_q == 40'(SCROLL_CYC - 1)) begin
            scrollCnt_q <= 40'h0;
            scrollNext <= 1'b1;
        end else begin
            scrollCnt_q <= scrollCnt_q + 40'h1;
            scrollNext <= 1'b0;
        end
    end

    // Lamp, sounder and release outputs
    logic manMeta_q;
    logic manSync_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            manMeta_q <= 1'b0;
            manSync_q <= 1'b0;
        end else begin
            manMeta_q <= manualReleasePin;
            manSync_q <= manMeta_q;
        end
    end
    pik_pkg::pik_lamps_s lampsD;
    always_comb begin
        lampsD.controlsActive = status.holdsControl;
        lampsD.power = status.acPower;
        lampsD.preDischarge = |preDischargeZones;
        lampsD.discharge = |dischargeZones;
        lampsD.abortActive = status.abortActive;
        lampsD.fireAlarm = catLamp[`PIK_CAT_FIRE];
        lampsD.preAlarm = catLamp[`PIK_CAT_PRE];
        lampsD.security = catLamp[`PIK_CAT_SEC];
        lampsD.supervisory = catLamp[`PIK_CAT_SUP];
        lampsD.trouble = catLamp[`PIK_CAT_TRB];
        lampsD.silenced = silenced_q && (!status.partialSilence || blink_q);
        lampsD.pointDisabled = status.disabledAny;
        if (lampTestHeld) begin
            lampsD = '1;
        end
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lamps <= '0;
            sounder <= 1'b0;
            silenceableOn <= 1'b0;
            releaseNow <= 1'b0;
            displayAllOn <= 1'b0;
            showRevision <= 1'b0;
        end else begin
            lamps <= lampsD;
            // Piezo stays silent under no-control even during lamp test
            sounder <= (sound_q || lampTestHeld) && !lcNone;
            silenceableOn <= nac_q;
            // Manual release ignores the abort input and the delay
            releaseNow <= manSync_q || (|dischargeZones);
            displayAllOn <= lampTestHeld && lampCnt_q != 40'(LAMP_REV_CYC);
            showRevision <= lampTestHeld && lampCnt_q == 40'(LAMP_REV_CYC);
        end
    end

    // Register read port, data one cycle after the strobe
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            regRdData <= 32'h0;
        end else if (!regRd) begin
            regRdData <= 32'h0;
        end else if (regAddr == `PIK_ADDR_CTRL) begin
            regRdData <= {30'h0, localCtrl_q};
        end else if (regAddr == `PIK_ADDR_STATUS) begin
            regRdData <= {11'h0, netDecouple, resettablePowerOff, nac_q, sound_q, unack_q, lamps};
        end else if (regAddr == `PIK_ADDR_LOG) begin
            regRdData <= {28'h0, lastLog_q};
        end else begin
            regRdData <= 32'h0;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence ackKey_s;
        keyPress_q[4] && !lcNone;
    endsequence
    ack_annunciator_a: assert property (ackKey_s |=> annunSilenceCmd && logValid)
        else $error("acknowledge did not command annunciators");
    ack_quiet_a: assert property ((ackKey_s and (!(|rise) && !reactivate)) |=> ##1 !sounder)
        else $error("sounder still on after acknowledge");
    nocontrol_quiet_a: assert property (lcNone |=> !sounder)
        else $error("sounder active under no control");
    silence_ignored_a: assert property (lcPartial |-> !silenceDo && !drillDo)
        else $error("silence or drill honoured under partial control");
    reset_decouple_a: assert property (resetDo |=> netDecouple && resettablePowerOff [*2])
        else $error("reset did not decouple or interrupt power");
    reset_log_a: assert property (resetDo |=> logValid && logCode == pik_pkg::PIK_LOG_RESET)
        else $error("reset message missing");
    drill_clears_a: assert property (drillDo |=> !silenced_q ##1 silenceableOn)
        else $error("drill did not clear silenced lamp and start circuits");
    manual_release_a: assert property (manSync_q |=> releaseNow)
        else $error("manual release not immediate");
    trouble_clear_a: assert property ($fell(condVec[4]) |=> ##1 !lamps.trouble || lampTestHeld)
        else $error("trouble lamp stuck after clear");
    discharge_lamp_a: assert property (!lampTestHeld && (|dischargeZones) |=> lamps.discharge)
        else $error("discharge lamp off while discharging");
endmodule

/* File: testbench/pik_operator.sv */
// Operator at the front panel, pressing and releasing keys
`timescale 1ns/1ps
module pik_operator (
    input wire logic clock,
    output pik_pkg::pik_keys_s keys
);
    initial keys = '0;
    // Keys change only right after an edge, like a real pin sampled by the sync stage
    task automatic down(input int k);
        keys[k] <= 1'b1;
    endtask
    task automatic up(input int k);
        keys[k] <= 1'b0;
    endtask
endmodule

/* File: testbench/pik_panel_control_tb.sv */
// Self-checking bench for the panel lamps and control keys
`timescale 1ns/1ps
`include "pik_consts.svh"
`define CHK(a, e, m) begin checks++; if ((a) !== (e)) begin err_total++; $display("wrong value at %0t: %s", $time, m); end end
module pik_panel_control_tb;
    logic clock = 1'b0, resetn = 1'b0, manualRel = 1'b0, regWr = 1'b0, regRd = 1'b0;
    pik_pkg::pik_keys_s keys;
    pik_pkg::pik_status_s status = '0;
    logic [3:0] preZ = '0, disZ = '0;
    logic [7:0] regAddr = '0;
    logic [31:0] regWrData = '0, rdv, rdq;
    pik_pkg::pik_lamps_s lamps;
    pik_pkg::pik_log_e logCode, lastCode;
    logic sounder, silOn, pwrOff, decouple, annun, logValid, relNow, allOn, showRev, scroll;
    int err_total = 0, checks = 0, logSeen = 0, annSeen = 0, pwrCyc = 0, decCyc = 0, scrCyc = 0, n0;
    initial forever #4 clock = ~clock;
    pik_operator i_op (.clock(clock), .keys(keys));
    pik_panel_control #(.ZONES(4), .SCROLL_CYC(40), .DECOUPLE_CYC(50), .DRILL_CYC(20), .LAMP_REV_CYC(30),
        .BLINK_CYC(4), .DEBOUNCE_CYC(4), .POWER_OFF_CYC(8)) i_dut (
        .clock(clock), .resetn(resetn), .keyPins(keys), .manualReleasePin(manualRel), .status(status),
        .preDischargeZones(preZ), .dischargeZones(disZ), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(rdv), .lamps(lamps), .sounder(sounder),
        .silenceableOn(silOn), .resettablePowerOff(pwrOff), .netDecouple(decouple),
        .annunSilenceCmd(annun), .logValid(logValid), .logCode(logCode), .scrollNext(scroll),
        .releaseNow(relNow), .displayAllOn(allOn), .showRevision(showRev));
    // Log, annunciator and scroll pulses last one cycle, power-off and decouple several, so all are counted here rather than polled
    always @(posedge clock) begin
        if (logValid === 1'b1) begin
            logSeen++;
            lastCode = logCode;
        end
        if (annun === 1'b1) annSeen++;
        if (pwrOff === 1'b1) pwrCyc++;
        if (decouple === 1'b1) decCyc++;
        if (scroll === 1'b1) scrCyc++;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        tick(1);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        regAddr <= a;
        regRd <= 1'b1;
        tick(1);
        regRd <= 1'b0;
        d = rdv;
    endtask
    // Hold a key until the block logs its action, bounded
    task automatic press(input int k);
        n0 = logSeen;
        i_op.down(k);
        for (int i = 0; i < 60 && logSeen == n0; i++) tick(1);
        i_op.up(k);
        if (logSeen == n0) begin
            err_total++;
            $display("wrong value at %0t: key action never logged", $time);
            tally_and_finish();
        end
        tick(2);
    endtask
    // Counts lit cycles of one lamp bit over 8 cycles: 8 steady, 4 flashing
    task automatic seen(input int b, output int n);
        n = 0;
        for (int i = 0; i < 8; i++) begin
            tick(1);
            n += int'(lamps[b] === 1'b1);
        end
    endtask
    task automatic categories();
        int n;
        status.multiEvents <= 1'b1;
        scrCyc = 0;
        tick(85);
        `CHK(scrCyc, 2, "scroll steps")
        status.securityCond <= 1'b1;
        status.supervisoryCond <= 1'b1;
        status.supervisoryLatching <= 1'b1;
        status.preAlarmCond <= 1'b1;
        status.preAlarmAction <= 1'b1;
        status.troubleCond <= 1'b0;
        tick(3);
        seen(4, n);
        `CHK(n, 4, "security lamp not flashing")
        `CHK(lamps.trouble, 1'b0, "trouble lamp after clear")
        press(4);
        seen(5, n);
        `CHK(n, 8, "pre-alarm lamp not steady")
        status.securityCond <= 1'b0;
        status.supervisoryCond <= 1'b0;
        status.preAlarmCond <= 1'b0;
        press(3);
        status.partialSilence <= 1'b1;
        tick(2);
        `CHK(lamps[5:3], 3'h7, "latched lamps released early")
        seen(1, n);
        `CHK(n, 4, "partial silence lamp not flashing")
        press(2);
        `CHK(lamps[5:1], 5'h0, "lamps after reset")
        $display("categories and scroll done");
    endtask
    task automatic fireAck();
        int tg = 0;
        logic p;
        status.fireCond <= 1'b1;
        tick(3);
        p = lamps.fireAlarm;
        for (int i = 0; i < 16; i++) begin tick(1); if (lamps.fireAlarm !== p) tg++; p = lamps.fireAlarm; end
        `CHK(tg >= 2, 1'b1, "fire lamp not flashing")
        `CHK(sounder, 1'b1, "sounder off in alarm")
        press(4);
        `CHK(lastCode, pik_pkg::PIK_LOG_ACK, "ack log code")
        `CHK(annSeen, 1, "annunciator silence count")
        `CHK(sounder, 1'b0, "sounder after ack")
        tg = 0;
        for (int i = 0; i < 12; i++) begin tick(1); if (lamps.fireAlarm !== 1'b1) tg++; end
        `CHK(tg, 0, "fire lamp not steady")
        $display("fire and acknowledge done");
    endtask
    task automatic silenceDrillReset();
        press(3);
        `CHK(lastCode, pik_pkg::PIK_LOG_SILENCE, "silence log code")
        `CHK({lamps.silenced, silOn}, 2'b10, "silence outputs")
        press(1);
        `CHK(lastCode, pik_pkg::PIK_LOG_EVAC, "drill log code")
        `CHK({lamps.silenced, silOn}, 2'b01, "drill outputs")
        status.fireCond <= 1'b0;
        status.troubleCond <= 1'b1;
        tick(3);
        `CHK(lamps.fireAlarm, 1'b1, "fire lamp not held")
        press(4);
        pwrCyc = 0;
        decCyc = 0;
        press(2);
        tick(60);
        `CHK(lastCode, pik_pkg::PIK_LOG_RESET, "reset log code")
        `CHK(pwrCyc, 8, "power interruption length")
        `CHK(decCyc, 50, "network detach length")
        `CHK({lamps.fireAlarm, lamps.trouble}, 2'b01, "lamps after reset")
        `CHK(sounder, 1'b1, "sounder not reactivated")
        $display("silence, drill and reset done");
    endtask
    task automatic localControl();
        int ks[6] = '{4, 3, 2, 1, 3, 1};
        for (int j = 0; j < 6; j++) begin
            if (j == 0) wr(`PIK_ADDR_CTRL, 32'h0000_0000);
            if (j == 4) wr(`PIK_ADDR_CTRL, 32'h0000_0002);
            n0 = logSeen;
            i_op.down(ks[j]);
            tick(40);
            i_op.up(ks[j]);
            tick(3);
            `CHK(logSeen, n0, "ignored key logged")
            if (j < 4) `CHK(sounder, 1'b0, "sounder with no control")
        end
        wr(`PIK_ADDR_CTRL, 32'h0000_0003);
        $display("local control done");
    endtask
    task automatic lampsAndTest();
        status.holdsControl <= 1'b1;
        status.disabledAny <= 1'b1;
        status.abortActive <= 1'b1;
        preZ <= 4'h4;
        disZ <= 4'h1;
        manualRel <= 1'b1;
        tick(6);
        `CHK({lamps[11:7], lamps.pointDisabled}, 6'h3f, "level lamps")
        `CHK(relNow, 1'b1, "manual release held off by abort")
        preZ <= 4'h0;
        disZ <= 4'h0;
        status.holdsControl <= 1'b0;
        status.disabledAny <= 1'b0;
        status.acPower <= 1'b0;
        tick(4);
        `CHK({lamps[11:7], lamps.pointDisabled}, 6'h02, "lamps cleared")
        `CHK(relNow, 1'b1, "manual release not immediate")
        i_op.down(0);
        tick(15);
        `CHK({allOn, showRev, sounder, lamps}, {3'h5, 12'hfff}, "lamp test display")
        tick(30);
        `CHK({allOn, showRev}, 2'b01, "revision display")
        i_op.up(0);
        tick(3);
        $display("lamps and lamp test done");
    endtask
    initial begin
        status.acPower = 1'b1;
        tick(2);
        `CHK(lamps, 12'h000, "lamps in reset")
        resetn <= 1'b1;
        tick(4);
        rd(`PIK_ADDR_CTRL, rdq);
        `CHK(rdq[1:0], 2'h3, "control reset value")
        wr(8'h0c, 32'hffff_ffff);
        rd(8'h0c, rdq);
        `CHK(rdq, 32'h0, "unmapped read")
        tick(1);
        rd(`PIK_ADDR_STATUS, rdq);
        `CHK(rdq, 32'h0000_0400, "status after reset")
        fireAck();
        silenceDrillReset();
        localControl();
        lampsAndTest();
        categories();
        tally_and_finish();
    end
endmodule
